// ==== rtl/gpio_port_pkg.sv ====
// constants and register layout of the general-purpose i/o port
package gpio_port_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PINS_PER_PORT = 8;
    localparam int BIT_SEL_W = 3;
    localparam int SEL_W = 2;

    // ------------------------------------------------------------
    // register map: port p occupies addresses p*4 .. p*4+2
    // ------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_INPUT = 2'h0;
    localparam logic [SEL_W-1:0] SEL_DIRECTION = 2'h1;
    localparam logic [SEL_W-1:0] SEL_OUTPUT = 2'h2;
    localparam logic [ADDR_W-1:0] CPU_CONTROL_ADDR = 8'hff;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int PULLUP_DISABLE_POS = 4;
    localparam logic [DATA_W-1:0] PORT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;

endpackage

// ==== rtl/general_purpose_io_port.sv ====
// general-purpose i/o ports with register access, pin control and input synchroniser
module general_purpose_io_port #(
    parameter int NUM_PORTS = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [gpio_port_pkg::ADDR_W-1:0] addr,
    input wire logic [gpio_port_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic set_io_bit_instr,
    input wire logic clear_io_bit_instr,
    input wire logic [gpio_port_pkg::BIT_SEL_W-1:0] bit_sel,
    output logic [gpio_port_pkg::DATA_W-1:0] rdata,
    // pins
    input wire logic [NUM_PORTS*gpio_port_pkg::PINS_PER_PORT-1:0] pin_in,
    output logic [NUM_PORTS*gpio_port_pkg::PINS_PER_PORT-1:0] pin_out,
    output logic [NUM_PORTS*gpio_port_pkg::PINS_PER_PORT-1:0] pin_oe,
    output logic [NUM_PORTS*gpio_port_pkg::PINS_PER_PORT-1:0] pin_pullup,
    // alternate function overrides
    input wire logic [NUM_PORTS*gpio_port_pkg::PINS_PER_PORT-1:0] alt_enable,
    input wire logic [NUM_PORTS*gpio_port_pkg::PINS_PER_PORT-1:0] alt_oe,
    input wire logic [NUM_PORTS*gpio_port_pkg::PINS_PER_PORT-1:0] alt_out,
    input wire logic [NUM_PORTS*gpio_port_pkg::PINS_PER_PORT-1:0] alt_pullup
);

    localparam int NPINS = NUM_PORTS * gpio_port_pkg::PINS_PER_PORT;
    localparam int IDX_W = gpio_port_pkg::ADDR_W - gpio_port_pkg::SEL_W;

    logic [gpio_port_pkg::DATA_W-1:0] port_direction_reg [NUM_PORTS];
    logic [gpio_port_pkg::DATA_W-1:0] port_output_reg [NUM_PORTS];
    logic [NPINS-1:0] port_input_reg;
    logic [NPINS-1:0] sync_latch;
    logic global_pullup_disable_reg;
    logic [gpio_port_pkg::DATA_W-1:0] rdata_reg;
    logic [gpio_port_pkg::DATA_W-1:0] rdata_next;
    logic [gpio_port_pkg::DATA_W-1:0] bit_mask;
    logic [IDX_W-1:0] port_idx;
    logic [gpio_port_pkg::SEL_W-1:0] reg_sel;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign port_idx = addr[gpio_port_pkg::ADDR_W-1:gpio_port_pkg::SEL_W];
    assign reg_sel = addr[gpio_port_pkg::SEL_W-1:0];
    assign bit_mask = gpio_port_pkg::BIT_ONE << bit_sel;

    // ------------------------------------------------------------
    // direction registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                port_direction_reg[p] <= gpio_port_pkg::PORT_RESET;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (port_idx == IDX_W'(p) && reg_sel == gpio_port_pkg::SEL_DIRECTION) begin
                    if (wr_en) begin
                        port_direction_reg[p] <= wdata;
                    end else if (set_io_bit_instr) begin
                        port_direction_reg[p] <= port_direction_reg[p] | bit_mask;
                    end else if (clear_io_bit_instr) begin
                        port_direction_reg[p] <= port_direction_reg[p] & ~bit_mask;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // output-data registers, with toggle through the input address
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                port_output_reg[p] <= gpio_port_pkg::PORT_RESET;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (port_idx == IDX_W'(p) && reg_sel == gpio_port_pkg::SEL_OUTPUT) begin
                    if (wr_en) begin
                        port_output_reg[p] <= wdata;
                    end else if (set_io_bit_instr) begin
                        port_output_reg[p] <= port_output_reg[p] | bit_mask;
                    end else if (clear_io_bit_instr) begin
                        port_output_reg[p] <= port_output_reg[p] & ~bit_mask;
                    end
                end else if (port_idx == IDX_W'(p) && reg_sel == gpio_port_pkg::SEL_INPUT) begin
                    if (wr_en) begin
                        port_output_reg[p] <= port_output_reg[p] ^ wdata;
                    end else if (set_io_bit_instr) begin
                        port_output_reg[p] <= port_output_reg[p] ^ bit_mask;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // cpu control register: global pull-up disable
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            global_pullup_disable_reg <= 1'b0;
        end else if (addr == gpio_port_pkg::CPU_CONTROL_ADDR) begin
            if (wr_en) begin
                global_pullup_disable_reg <= wdata[gpio_port_pkg::PULLUP_DISABLE_POS];
            end else if (set_io_bit_instr
                && bit_sel == gpio_port_pkg::BIT_SEL_W'(gpio_port_pkg::PULLUP_DISABLE_POS)) begin
                global_pullup_disable_reg <= 1'b1;
            end else if (clear_io_bit_instr
                && bit_sel == gpio_port_pkg::BIT_SEL_W'(gpio_port_pkg::PULLUP_DISABLE_POS)) begin
                global_pullup_disable_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // pin control
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (alt_enable[i]) begin
                pin_oe[i] = alt_oe[i] & ~rst;
                pin_out[i] = alt_out[i];
                pin_pullup[i] = alt_pullup[i] & ~rst;
            end else begin
                pin_oe[i] = port_direction_reg[i / 8][i % 8];
                pin_out[i] = port_output_reg[i / 8][i % 8];
                pin_pullup[i] = ~port_direction_reg[i / 8][i % 8]
                    & port_output_reg[i / 8][i % 8]
                    & ~global_pullup_disable_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // input synchroniser: latch open while clock high, then a flop
    // ------------------------------------------------------------
    always_latch begin
        if (core_clk) begin
            sync_latch <= pin_in;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_input_reg <= '0;
        end else begin
            port_input_reg <= sync_latch;
        end
    end

    // ------------------------------------------------------------
    // read path, data one cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = gpio_port_pkg::UNMAPPED_READ;
        if (addr == gpio_port_pkg::CPU_CONTROL_ADDR) begin
            rdata_next[gpio_port_pkg::PULLUP_DISABLE_POS] = global_pullup_disable_reg;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (port_idx == IDX_W'(p)) begin
                    case (reg_sel)
                        gpio_port_pkg::SEL_INPUT: begin
                            rdata_next = port_input_reg[p*8 +: 8];
                        end
                        gpio_port_pkg::SEL_DIRECTION: begin
                            rdata_next = port_direction_reg[p];
                        end
                        gpio_port_pkg::SEL_OUTPUT: begin
                            rdata_next = port_output_reg[p];
                        end
                        default: begin
                            rdata_next = gpio_port_pkg::UNMAPPED_READ;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= gpio_port_pkg::UNMAPPED_READ;
        end else if (rd_en) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= gpio_port_pkg::UNMAPPED_READ;
        end
    end

    assign rdata = rdata_reg;

endmodule // general_purpose_io_port

// ==== sim/gpio_port_properties.sv ====
// assertion checker for the general-purpose i/o port
module gpio_port_checker #(
    parameter int NUM_PORTS = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic set_io_bit_instr,
    input wire logic clear_io_bit_instr,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] rdata,
    input wire logic [NUM_PORTS*8-1:0] pin_in, pin_out, pin_oe, pin_pullup,
    input wire logic [NUM_PORTS*8-1:0] alt_enable, alt_oe, alt_out, alt_pullup
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic gp;
    assign gp = alt_enable[7:0] == 8'h00;
    AST_RESET_TRI: assert property (disable iff (1'b0) rst |-> pin_oe == '0)
        else $error("pins driven during reset");
    AST_DIR_OE: assert property (wr_en && addr == 8'h01 && gp |=> pin_oe[7:0] == $past(wdata))
        else $error("direction write not seen on output enables");
    AST_OUT_LEVEL: assert property (wr_en && addr == 8'h02 && gp
        |=> ((pin_out[7:0] ^ $past(wdata)) & pin_oe[7:0]) == 8'h00) else $error("drive level wrong");
    AST_PULL_OFF: assert property (wr_en && addr == 8'hff && wdata[4] && gp
        |=> pin_pullup[7:0] == 8'h00) else $error("pull-up left on after global disable");
    AST_TOGGLE: assert property (wr_en && addr == 8'h00 && gp |=> ((pin_out[7:0]
        ^ $past(pin_out[7:0]) ^ $past(wdata)) & pin_oe[7:0] & $past(pin_oe[7:0])) == 8'h00)
        else $error("input write did not toggle output bits");
    AST_RDATA_IDLE: assert property (!rd_en |=> rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_LOOPBACK: assert property (wr_en && addr == 8'h02 && gp ##1 !wr_en ##1 rd_en && addr == 8'h00
        |=> ((rdata ^ $past(wdata, 3)) & $past(pin_oe[7:0])) == 8'h00) else $error("loopback late");
    AST_BIT_SET: assert property (set_io_bit_instr && addr == 8'h01 && gp
        |=> pin_oe[7:0] == ($past(pin_oe[7:0]) | (8'h01 << $past(bit_sel))))
        else $error("single-bit set disturbed other pins");
endmodule // gpio_port_checker

bind general_purpose_io_port gpio_port_checker #(.NUM_PORTS(NUM_PORTS)) i_gpio_port_checker (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .set_io_bit_instr(set_io_bit_instr), .clear_io_bit_instr(clear_io_bit_instr),
    .bit_sel(bit_sel), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .alt_enable(alt_enable), .alt_oe(alt_oe), .alt_out(alt_out),
    .alt_pullup(alt_pullup));

// ==== sim/pin_partner.sv ====
// model of the board circuitry on the port pins
module pin_partner (
    input wire logic core_clk,
    input wire logic [7:0] pin_out, pin_oe, pin_pullup,
    input wire logic [7:0] ext_en, ext_val,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // an undriven pin wanders so no floating level passes for a real one
    logic [7:0] float_pat = 8'h55;
    always @(posedge core_clk) float_pat <= ~float_pat;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | float_pat));
endmodule // pin_partner

// ==== sim/test_general_purpose_io_port.sv ====
// self-checking bench for the general-purpose i/o port
module test_general_purpose_io_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] stb = 4'h0;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pin_in, pin_out, pin_oe, pin_pullup;
    logic [7:0] alt_en = 8'h00, alt_oe = 8'h00, alt_out = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    int err_total = 0;
    int num_checks = 0;
    always #2.5 core_clk = ~core_clk;
    general_purpose_io_port #(.NUM_PORTS(1)) i_general_purpose_io_port (.core_clk(core_clk),
        .rst(rst), .addr(addr), .wdata(wdata), .wr_en(stb[3]), .rd_en(stb[2]),
        .set_io_bit_instr(stb[1]), .clear_io_bit_instr(stb[0]), .bit_sel(bit_sel), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .alt_enable(alt_en), .alt_oe(alt_oe), .alt_out(alt_out), .alt_pullup(8'h00));
    pin_partner i_pin_partner (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobes: 8 write, 4 read, 2 bit set, 1 bit clear
    task automatic bus(input logic [3:0] s, input logic [7:0] a, d, input logic [2:0] b = 3'h0);
        @(posedge core_clk);
        stb <= s;
        addr <= a;
        wdata <= d;
        bit_sel <= b;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        bus(4'h4, a, 8'h00);
        bus(4'h0, a, 8'h00);
        #1 chk(rdata, exp);
    endtask
    task automatic pins(input logic [7:0] oe, pu, drv);
        bus(4'h0, 8'h00, 8'h00);
        #1 chk(pin_oe, oe);
        chk(pin_pullup, pu);
        chk(pin_out & pin_oe, drv);
    endtask
    task automatic t_reset;
        pins(8'h00, 8'h00, 8'h00);
        rd(8'h01, 8'h00);
        bus(4'h8, 8'h01, 8'hff);
        pins(8'hff, 8'h00, 8'h00);
        #1 rst <= 1'b1;
        #1 chk(pin_oe, 8'h00);
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        pins(8'h00, 8'h00, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_drive;
        bus(4'h8, 8'h01, 8'h0f); // output-low before output-high
        pins(8'h0f, 8'h00, 8'h00);
        bus(4'h8, 8'h02, 8'hf5);
        bus(4'h0, 8'h00, 8'h00); // idle cycle before reading back
        rd(8'h00, 8'hf5);
        pins(8'h0f, 8'hf0, 8'h05);
        rd(8'h01, 8'h0f);
        bus(4'h8, 8'h00, 8'hff);
        rd(8'h02, 8'h0a);
        bus(4'h8, 8'h01, 8'h00);
        pins(8'h00, 8'h0a, 8'h00);
        bus(4'h8, 8'hff, 8'h10);
        pins(8'h00, 8'h00, 8'h00);
        bus(4'h8, 8'hff, 8'h00);
        pins(8'h00, 8'h0a, 8'h00);
        bus(4'h8, 8'h02, 8'h00); // tri-state before any output-low
        pins(8'h00, 8'h00, 8'h00);
        $display("test drive done");
    endtask
    task automatic t_bits;
        bus(4'h8, 8'h01, 8'h21);
        bus(4'h2, 8'h01, 8'h00, 3'h6);
        bus(4'h1, 8'h01, 8'h00, 3'h0);
        bus(4'h2, 8'h02, 8'h00, 3'h6);
        pins(8'h60, 8'h00, 8'h40);
        bus(4'h1, 8'h01, 8'h00, 3'h6);
        bus(4'h2, 8'h00, 8'h00, 3'h1);
        pins(8'h20, 8'h42, 8'h00);
        bus(4'h8, 8'h40, 8'hff);
        rd(8'h40, 8'h00);
        rd(8'h02, 8'h42);
        $display("test bits done");
    endtask
    task automatic t_sync;
        #2 ext_en <= 8'hff;
        ext_val <= 8'h3c;
        bus(4'h0, 8'h00, 8'h00);
        rd(8'h00, 8'h1c);
        alt_en <= 8'h80;
        alt_oe <= 8'h80;
        alt_out <= 8'h80;
        bus(4'h8, 8'h01, 8'h01);
        pins(8'h81, 8'h42, 8'h80);
        alt_en <= 8'h00;
        $display("test sync done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_drive;
        t_bits;
        t_sync;
        end_sim;
    end
    initial begin
        #20000;
        err_total++;
        end_sim;
    end
endmodule // test_general_purpose_io_port
